/* File: rtl/asq_top.v */
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`include "asq_regs.vh"

module asq_top #(
  parameter DIV_W = 8
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Serial pins
  input  wire        bit_clock_in,
  output wire        bit_clock_out,
  output wire        bit_clock_oe,
  input  wire        frame_select_in,
  output wire        frame_select_out,
  output wire        frame_select_oe,
  output wire        master_clock_out,
  output wire        master_clock_oe,
  output wire        sd_out,
  output wire        sd_oe,
  input  wire        sd_in,
  // Interrupt
  output wire        irq
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [`ASQ_CFG_W-1:0] cfg_q;
  reg [2:0]            irq_en_q;
  reg [DIV_W+1:0]      pre_q;
  reg [15:0]           tx_buf_q;
  reg                  tx_full_q;
  reg                  tx_empty_q;
  reg [15:0]           tx_sh_q;
  reg [15:0]           rx_sh_q;
  reg [15:0]           rx_buf_q;
  reg                  rx_full_q;
  reg                  side_flag_q;
  reg                  udr_q;
  reg                  ovr_q;
  reg                  ovr_armed_q;
  reg                  started_q;
  reg                  run_q;
  reg [4:0]            slot_q;
  reg                  side_q;
  reg                  ws_seen_q;
  reg [DIV_W:0]        div_cnt_q;
  reg [3:0]            sub_cnt_q;
  reg                  mclk_q;
  reg                  bck_q;
  reg                  bck_in_prev_q;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  wire       en        = cfg_q[`ASQ_CFG_EN] & cfg_q[`ASQ_CFG_MODE];
  wire       is_master = cfg_q[`ASQ_CFG_ROLE_HI];
  wire       is_rx     = cfg_q[`ASQ_CFG_ROLE_LO];
  wire       cpol      = cfg_q[`ASQ_CFG_CPOL];
  wire       chan32    = cfg_q[`ASQ_CFG_CLEN];
  wire [1:0] dlen      = cfg_q[`ASQ_CFG_DLEN_HI:`ASQ_CFG_DLEN_LO];
  wire       mck_en    = pre_q[`ASQ_PRE_MASTER_CLOCK_OUT_ENABLE];
  // 16-bit data inside a 32-bit channel: second half is padding
  wire       pad_mode  = chan32 & (dlen == `ASQ_DLEN_16);
  wire [4:0] slot_last = chan32 ? `ASQ_SLOT_LAST32 : `ASQ_SLOT_LAST16;

  // Register decode, used by both read and write paths
  function hit;
    input [3:0] a;
    input [3:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_cfg  = reg_wr & hit(reg_addr, `ASQ_OFS_CFG);
  wire wr_irq  = reg_wr & hit(reg_addr, `ASQ_OFS_IRQ);
  wire wr_pre  = reg_wr & hit(reg_addr, `ASQ_OFS_PRE);
  wire wr_data = reg_wr & hit(reg_addr, `ASQ_OFS_DATA);
  wire rd_data = reg_rd & hit(reg_addr, `ASQ_OFS_DATA);
  wire rd_stat = reg_rd & hit(reg_addr, `ASQ_OFS_STATUS);

  // ----------------------------------------------------------------
  // Master clock generation
  // ----------------------------------------------------------------
  // Master runs once enabled; transmit waits for the first word
  wire run_m   = en & is_master & (is_rx | started_q);
  wire [DIV_W:0] half = {pre_q[DIV_W-1:0], pre_q[`ASQ_PRE_ODD]};
  // A zero divider would stall the counter, so treat it as one
  wire [DIV_W:0] half_m1 = (half == {(DIV_W+1){1'b0}}) ? {(DIV_W+1){1'b0}} : half - 1'b1;
  wire tick    = run_m & (div_cnt_q >= half_m1);
  wire [3:0] sub_last = mck_en ? (chan32 ? `ASQ_MCK_DIV32 : `ASQ_MCK_DIV16) - 1'b1 : 4'h0;
  wire bck_tgl = tick & (sub_cnt_q == sub_last);

  // Divider chain: ticks feed master clock, bit clock derives from it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= {(DIV_W+1){1'b0}};
      sub_cnt_q <= 4'h0;
      mclk_q    <= 1'b0;
      bck_q     <= 1'b0;
    end else if (!run_m) begin
      div_cnt_q <= {(DIV_W+1){1'b0}};
      sub_cnt_q <= 4'h0;
      mclk_q    <= 1'b0;
      bck_q     <= 1'b0;
    end else begin
      div_cnt_q <= tick ? {(DIV_W+1){1'b0}} : div_cnt_q + 1'b1;
      if (tick) begin
        mclk_q    <= ~mclk_q;
        sub_cnt_q <= bck_tgl ? 4'h0 : sub_cnt_q + 1'b1;
      end
      if (bck_tgl)
        bck_q <= ~bck_q;
    end
  end

  // ----------------------------------------------------------------
  // Bit edges for both roles
  // ----------------------------------------------------------------
  // Slave clock is taken as synchronous; only the previous level is kept
  wire bck_in_n = bit_clock_in ^ cpol;
  wire drv_s    = en & ~is_master & bck_in_n & ~bck_in_prev_q;
  wire smp_s    = en & ~is_master & ~bck_in_n & bck_in_prev_q;
  wire drv_m    = bck_tgl & ~bck_q;
  wire smp_m    = bck_tgl & bck_q;
  wire drv      = is_master ? drv_m : drv_s;
  wire smp      = is_master ? smp_m : smp_s;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      bck_in_prev_q <= 1'b0;
    else
      bck_in_prev_q <= bck_in_n;
  end

  // Next slot: slave realigns on a word select change
  wire ws_chg    = ws_seen_q ^ frame_select_in;
  wire [4:0] nslot = (!run_q || (!is_master && ws_chg) || slot_q == slot_last) ? 5'h00 : slot_q + 1'b1;
  wire pkt_start = (nslot[3:0] == 4'h0) & ~(pad_mode & nslot[4]);
  // Channel of the word being started
  wire nside     = is_master ? (!run_q ? 1'b1 : (nslot == 5'h00 ? ~side_q : side_q))
                             : frame_select_in;
  // Next word channel: same channel for a second packet, else the other one
  wire next_side = (chan32 & ~pad_mode & (nslot == 5'h00)) ? nside : ~nside;
  wire pkt_done  = smp & run_q & (slot_q[3:0] == 4'hF) & ~(pad_mode & slot_q[4]);
  wire tx_mode   = en & ~is_rx;
  wire rx_mode   = en & is_rx;

  // ----------------------------------------------------------------
  // Framing and transmit shifter
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q     <= 1'b0;
      slot_q    <= 5'h00;
      side_q    <= 1'b1;
      ws_seen_q <= 1'b0;
      tx_sh_q   <= 16'h0000;
    end else if (!en) begin
      run_q     <= 1'b0;
      slot_q    <= 5'h00;
      side_q    <= 1'b1;
      ws_seen_q <= frame_select_in;
      tx_sh_q   <= 16'h0000;
    end else if (drv) begin
      run_q     <= 1'b1;
      slot_q    <= nslot;
      side_q    <= nside;
      ws_seen_q <= frame_select_in;
      // Load in the first bit period, then shift MSB first
      if (pkt_start && tx_mode && tx_full_q)
        tx_sh_q <= tx_buf_q;
      else if (pkt_start)
        tx_sh_q <= 16'h0000;
      else
        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer and flags
  // ----------------------------------------------------------------
  wire tx_load = drv & pkt_start & tx_mode & tx_full_q;
  wire tx_miss = drv & pkt_start & tx_mode & ~tx_full_q & ~is_master & run_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_q   <= 16'h0000;
      tx_full_q  <= 1'b0;
      tx_empty_q <= 1'b0;
      started_q  <= 1'b0;
    end else if (!en) begin
      // Disable drops any pending word and clears the empty flag
      tx_full_q  <= 1'b0;
      tx_empty_q <= 1'b0;
      started_q  <= 1'b0;
      if (wr_data)
        tx_buf_q <= reg_wdata;
    end else begin
      if (wr_data) begin
        tx_buf_q  <= reg_wdata;
        started_q <= started_q | ~is_rx;
      end
      // A write in the load cycle refills the buffer: write wins
      if (wr_data && !is_rx) begin
        tx_full_q  <= 1'b1;
        tx_empty_q <= 1'b0;
      end else if (tx_load) begin
        tx_full_q  <= 1'b0;
        tx_empty_q <= 1'b1;
      end else if (!tx_full_q && !is_rx && !started_q) begin
        tx_empty_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter and buffer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q   <= 16'h0000;
      rx_buf_q  <= 16'h0000;
      rx_full_q <= 1'b0;
    end else begin
      if (smp && rx_mode)
        rx_sh_q <= {rx_sh_q[14:0], sd_in};
      // A same-cycle read beats completion into a full buffer, so that packet is lost
      if (pkt_done && rx_mode && !rx_full_q) begin
        rx_buf_q  <= {rx_sh_q[14:0], sd_in};
        rx_full_q <= 1'b1;
      end else if (rd_data || !en) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel side and error flags
  // ----------------------------------------------------------------
  wire ovr_set = pkt_done & rx_mode & rx_full_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      side_flag_q <= 1'b0;
      udr_q       <= 1'b0;
      ovr_q       <= 1'b0;
      ovr_armed_q <= 1'b0;
    end else begin
      if (tx_load)
        side_flag_q <= next_side;
      else if (pkt_done && rx_mode && !rx_full_q)
        side_flag_q <= side_q;
      // Underrun: set beats the clearing status read
      if (tx_miss)
        udr_q <= 1'b1;
      else if (rd_stat)
        udr_q <= 1'b0;
      // Overrun needs a data read, then a status read
      if (ovr_set) begin
        ovr_q       <= 1'b1;
        ovr_armed_q <= 1'b0;
      end else if (rd_stat && ovr_armed_q) begin
        ovr_q       <= 1'b0;
        ovr_armed_q <= 1'b0;
      end else if (rd_data && ovr_q) begin
        ovr_armed_q <= 1'b1;
      end
    end
  end

  // Busy: never in master receive, else while the link runs
  wire busy = run_q & ~(is_master & is_rx);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q    <= {`ASQ_CFG_W{1'b0}};
      irq_en_q <= 3'h0;
      pre_q    <= `ASQ_PRE_RESET;
    end else begin
      if (wr_cfg)
        cfg_q <= reg_wdata[`ASQ_CFG_W-1:0];
      if (wr_irq)
        irq_en_q <= reg_wdata[2:0];
      if (wr_pre)
        pre_q <= reg_wdata[DIV_W+1:0];
    end
  end

  // ----------------------------------------------------------------
  // Register reads, answered one cycle later
  // ----------------------------------------------------------------
  reg [15:0] rd_mux;

  always @* begin
    rd_mux = 16'h0000;
    if (hit(reg_addr, `ASQ_OFS_CFG))
      rd_mux[`ASQ_CFG_W-1:0] = cfg_q;
    else if (hit(reg_addr, `ASQ_OFS_IRQ))
      rd_mux[2:0] = irq_en_q;
    else if (hit(reg_addr, `ASQ_OFS_PRE))
      rd_mux[DIV_W+1:0] = pre_q;
    else if (hit(reg_addr, `ASQ_OFS_DATA))
      rd_mux = rx_buf_q;
    else if (hit(reg_addr, `ASQ_OFS_STATUS)) begin
      rd_mux[`ASQ_ST_RXF]  = rx_full_q;
      rd_mux[`ASQ_ST_TXE]  = tx_empty_q;
      rd_mux[`ASQ_ST_SIDE] = side_flag_q;
      rd_mux[`ASQ_ST_UDR]  = udr_q;
      rd_mux[`ASQ_ST_OVR]  = ovr_q;
      rd_mux[`ASQ_ST_BUSY] = busy;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------
  // Idle level of the bit clock follows the polarity bit
  assign bit_clock_out    = bck_q ^ cpol;
  assign bit_clock_oe     = en & is_master;
  // Select high marks the left channel in both roles
  assign frame_select_out = side_q;
  assign frame_select_oe  = en & is_master;
  assign master_clock_out = mclk_q & mck_en;
  assign master_clock_oe  = en & is_master & mck_en;
  assign sd_out           = tx_sh_q[15];
  assign sd_oe            = tx_mode;
  assign irq = (tx_empty_q & irq_en_q[`ASQ_IRQ_TXE]) |
               (rx_full_q & irq_en_q[`ASQ_IRQ_RXF]) |
               ((ovr_q | udr_q) & irq_en_q[`ASQ_IRQ_ERR]);

endmodule

/* File: shared/asq_regs.vh */
// Contract
// - Master role drives bit clock and word select pins as outputs.
// - Idle polarity sets bit clock rest level; master clock only when enabled.
// - Master clock pin is an output only while its enable is set.
// - Master transmit starts after first buffer write; first word is left.
// - Buffer-to-shifter move sets tx empty flag; interrupt if enabled.
// - Channel side updates as tx empty rises; marks channel of received words.
// - Every frame is left word then right word; no left-only frame.
// - Buffered half-word loads in first bit period, shifts out MSB first.
// - Receive delivers 16-bit packets; full sets flag, data read clears.
// - Word arriving while previous unread sets overrun; interrupt if enabled.
// - Busy flag stays low throughout master reception.
// - Slave role generates no clock; external master drives clock and select.
// - Slave channel side follows word select; asserted select means left.
// - Slave transmit without new word at next word start sets underrun.
// - Status register read clears underrun flag.
// - Overrun clears only after data read followed by status read.
`ifndef ASQ_REGS_VH
`define ASQ_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASQ_OFS_CFG     4'h0
`define ASQ_OFS_IRQ     4'h4
`define ASQ_OFS_PRE     4'h8
`define ASQ_OFS_DATA    4'hC
`define ASQ_OFS_STAT    4'h0 + 4'h0
`define ASQ_OFS_STATUS  4'h1

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define ASQ_CFG_EN      0
`define ASQ_CFG_MODE    1
`define ASQ_CFG_ROLE_LO 2
`define ASQ_CFG_ROLE_HI 3
`define ASQ_CFG_STD_LO  4
`define ASQ_CFG_STD_HI  5
`define ASQ_CFG_PCMS    6
`define ASQ_CFG_DLEN_LO 7
`define ASQ_CFG_DLEN_HI 8
`define ASQ_CFG_CLEN    9
`define ASQ_CFG_CPOL    10
`define ASQ_CFG_W       11

// ----------------------------------------------------------------
// Interrupt enables, prescaler and status fields
// ----------------------------------------------------------------
`define ASQ_IRQ_TXE     0
`define ASQ_IRQ_RXF     1
`define ASQ_IRQ_ERR     2
`define ASQ_PRE_ODD     8
`define ASQ_PRE_MASTER_CLOCK_OUT_ENABLE   9
`define ASQ_ST_RXF      0
`define ASQ_ST_TXE      1
`define ASQ_ST_SIDE     2
`define ASQ_ST_UDR      3
`define ASQ_ST_OVR      6
`define ASQ_ST_BUSY     7

// ----------------------------------------------------------------
// Framing constants
// ----------------------------------------------------------------
`define ASQ_SLOT_LAST16 5'h0F
`define ASQ_SLOT_LAST32 5'h1F
`define ASQ_MCK_DIV16   4'h8
`define ASQ_MCK_DIV32   4'h4
`define ASQ_DLEN_16     2'h0
`define ASQ_STD_LSB     2'h2
`define ASQ_PRE_RESET   10'h002

`endif

/* File: sim/asq_top_sva.sv */
`timescale 1ns/1ns
module asq_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Register port
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // Pins
  input wire        bit_clock_out,
  input wire        bit_clock_oe,
  input wire        frame_select_oe,
  input wire        master_clock_oe,
  input wire        irq
);
  reg [10:0] cfg_q;
  reg [2:0]  ien_q;
  reg        mck_q;
  reg        seen_q;
  wire       run = cfg_q[0] & cfg_q[1];
  wire       men = run & cfg_q[3];

  // Shadow of the settings, since the bodies stay hidden from us
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 11'h000;
      ien_q <= 3'h0;
      mck_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 4'h0) cfg_q <= reg_wdata[10:0];
      if (reg_addr == 4'h4) ien_q <= reg_wdata[2:0];
      if (reg_addr == 4'h8) mck_q <= reg_wdata[9];
      seen_q <= (reg_addr == 4'hC) | (seen_q & (reg_addr != 4'h0));
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------
  // Bus sequences
  // ------
  sequence s_stat_rd;
    reg_rd && reg_addr == 4'h1;
  endsequence
  sequence s_data_rd;
    reg_rd && reg_addr == 4'hC;
  endsequence

  // ------
  // Properties
  // ------
  // Stable settings allow for a registered enable
  property p_master_pins; men && $stable(cfg_q) |-> bit_clock_oe && frame_select_oe; endproperty
  a_master_pins: assert property (p_master_pins) else $error("master pins not driven");
  property p_slave_quiet; run && !cfg_q[3] && $stable(cfg_q) |-> !bit_clock_oe && !master_clock_oe; endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives a clock");
  property p_mck_oe; master_clock_oe |-> men && mck_q; endproperty
  a_mck_oe: assert property (p_mck_oe) else $error("master clock driven while off");
  property p_idle_lvl; (!cfg_q[0] && $stable(cfg_q)) [*2] |-> bit_clock_out == cfg_q[10]; endproperty
  a_idle_lvl: assert property (p_idle_lvl) else $error("bit clock not at idle level");
  property p_tx_wait; men && !cfg_q[2] && !seen_q |-> bit_clock_out == cfg_q[10]; endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("clock ran before first word");
  property p_txe_irq; s_stat_rd ##1 (reg_rdata[1] && ien_q[0]) |-> irq; endproperty
  a_txe_irq: assert property (p_txe_irq) else $error("empty flag without interrupt");
  property p_rxf_irq; s_stat_rd ##1 (reg_rdata[0] && ien_q[1]) |-> irq; endproperty
  a_rxf_irq: assert property (p_rxf_irq) else $error("full flag without interrupt");
  property p_rxf_clr; s_data_rd ##1 s_stat_rd |=> !reg_rdata[0]; endproperty
  a_rxf_clr: assert property (p_rxf_clr) else $error("full flag survived data read");
  property p_busy_mrx; (run && cfg_q[3:2] == 2'h3) ##0 s_stat_rd |=> !reg_rdata[7]; endproperty
  a_busy_mrx: assert property (p_busy_mrx) else $error("busy during master receive");
endmodule

bind asq_top asq_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clock_out(bit_clock_out),
  .bit_clock_oe(bit_clock_oe), .frame_select_oe(frame_select_oe), .master_clock_oe(master_clock_oe), .irq(irq));

/* File: sim/asq_codec.sv */
`timescale 1ns/1ns
module asq_codec (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Bench control
  input  wire        slave_run,
  // Device pins
  input  wire        bit_clock_out,
  input  wire        bit_clock_oe,
  input  wire        frame_select_out,
  input  wire        sd_out,
  output reg         bit_clock_in,
  output reg         frame_select_in,
  output reg         sd_in,
  // First word heard
  output reg  [15:0] word_q,
  output reg         ws_q,
  output wire        done
);
  reg       last_q;
  reg [4:0] cnt_q;
  reg [1:0] div_q;
  reg [3:0] slot_q;
  assign done = (cnt_q == 5'h10);

  // Listener on the master link, sampling on falling edges of the bit clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
      cnt_q <= 5'h00;
      word_q <= 16'h0000;
      ws_q <= 1'b0;
    end else begin
      last_q <= bit_clock_out;
      if (!bit_clock_oe) begin
        cnt_q <= 5'h00;
      end else if (last_q && !bit_clock_out && !done) begin
        word_q <= {word_q[14:0], sd_out};
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'h00) ws_q <= frame_select_out;
      end
    end
  end

  // External master in slave runs; clock stands still while slave_run is low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_clock_in <= 1'b0;
      frame_select_in <= 1'b0;
      sd_in <= 1'b0;
      div_q <= 2'h0;
      slot_q <= 4'h0;
    end else begin
      // Left slots carry ones, right zeros; a released line keeps toggling
      sd_in <= bit_clock_oe ? frame_select_out : ~sd_in;
      div_q <= div_q + 2'h1;
      if (!slave_run) begin
        div_q <= 2'h0;
        bit_clock_in <= 1'b0;
      end else if (div_q == 2'h3) begin
        bit_clock_in <= ~bit_clock_in;
        if (!bit_clock_in) begin
          slot_q <= slot_q + 4'h1;
          if (slot_q == 4'h0) frame_select_in <= ~frame_select_in;
        end
      end
    end
  end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  // Bench drive
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         slave_run = 1'b0;
  // Device outputs and partner lines
  wire [15:0] reg_rdata, word_q;
  wire        bit_clock_in, bit_clock_out, bit_clock_oe, frame_select_in, frame_select_out, frame_select_oe;
  wire        master_clock_out, master_clock_oe, sd_out, sd_oe, sd_in, irq, ws_q, done;
  integer     mismatches = 0;
  integer     checks = 0;
  integer     cyc = 0;
  reg  [15:0] d, d0;
  reg         side;

  always #10 clk = ~clk;

  asq_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clock_in(bit_clock_in), .bit_clock_out(bit_clock_out),
    .bit_clock_oe(bit_clock_oe), .frame_select_in(frame_select_in), .frame_select_out(frame_select_out),
    .frame_select_oe(frame_select_oe), .master_clock_out(master_clock_out), .master_clock_oe(master_clock_oe),
    .sd_out(sd_out), .sd_oe(sd_oe), .sd_in(sd_in), .irq(irq));
  asq_codec codec (.clk(clk), .rst_n(rst_n), .slave_run(slave_run), .bit_clock_out(bit_clock_out),
    .bit_clock_oe(bit_clock_oe), .frame_select_out(frame_select_out), .sd_out(sd_out),
    .bit_clock_in(bit_clock_in), .frame_select_in(frame_select_in), .sd_in(sd_in), .word_q(word_q),
    .ws_q(ws_q), .done(done));

  // ------
  // Helpers
  // ------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // Data read then status read with no gap between the strobes
  task rd_ds;
    begin
      @(posedge clk);
      reg_addr <= 4'hC;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_addr <= 4'h1;
      #1 d0 = reg_rdata;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // Bounded wait on one status bit
  task poll(input integer b, input integer lim);
    integer n;
    begin
      rd(4'h1);
      for (n = 0; n < lim && d[b] !== 1'b1; n = n + 1) rd(4'h1);
      chk(d[b], 16'h0001);
    end
  endtask
  task wrap_up;
    begin
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  // ------
  // Scenarios
  // ------
  task t_regs;
    begin
      rd(4'h8);
      chk(d, 16'h0002);
      wr(4'h2, 16'hFFFF);
      rd(4'h2);
      chk(d, 16'h0000);
    end
  endtask
  task t_mtx;
    begin
      wr(4'h8, 16'h0002);
      wr(4'h4, 16'h0001);
      wr(4'h0, 16'h001B);
      repeat (40) @(posedge clk);
      chk(bit_clock_oe, 16'h0001);
      chk(frame_select_oe, 16'h0001);
      chk(master_clock_oe, 16'h0000);
      chk(sd_oe, 16'h0001);
      chk(done, 16'h0000);
      wr(4'hC, 16'hA5C3);
      poll(1, 100);
      side = d[2];
      chk(irq, 16'h0001);
      wr(4'hC, 16'h3C5A);
      poll(1, 200);
      chk(d[2] ^ side, 16'h0001);
      while (done !== 1'b1 && cyc < 20000) @(negedge clk);
      chk(word_q, 16'hA5C3);
      chk(ws_q, 16'h0001);
      poll(1, 200);
      wr(4'h0, 16'h0000);
    end
  endtask
  task t_mrx;
    begin
      wr(4'h8, 16'h0202);
      wr(4'h4, 16'h0006);
      wr(4'h0, 16'h001F);
      @(negedge clk);
      chk(master_clock_oe, 16'h0001);
      // Master clock toggles once per divider tick of four cycles
      side = master_clock_out;
      repeat (4) @(negedge clk);
      chk(master_clock_out ^ side, 16'h0001);
      poll(0, 1500);
      chk(irq, 16'h0001);
      rd_ds;
      chk(d0, 16'hFFFF);
      chk(d[0], 16'h0000);
      poll(0, 1500);
      rd(4'hC);
      chk(d, 16'h0000);
      wr(4'h4, 16'h0004);
      poll(0, 1500);
      repeat (1200) @(posedge clk);
      rd(4'h1);
      chk(d[6], 16'h0001);
      chk(irq, 16'h0001);
      rd(4'h1);
      chk(d[6], 16'h0001);
      rd(4'hC);
      rd(4'h1);
      rd(4'h1);
      chk(d[6], 16'h0000);
      wr(4'h0, 16'h0000);
    end
  endtask
  // 16-bit data in 32-bit channels, idle polarity high; padding gives no packet
  task t_pad;
    begin
      wr(4'h8, 16'h0002);
      wr(4'h0, 16'h062F);
      poll(0, 400);
      chk(d[2], 16'h0001);
      rd(4'hC);
      chk(d, 16'hFFFF);
      repeat (136) @(posedge clk);
      wr(4'h0, 16'h0400);
      repeat (2) @(negedge clk);
      chk(bit_clock_out, 16'h0001);
      wr(4'h0, 16'h061F);
      poll(0, 400);
      rd(4'hC);
      chk(d, 16'hFFFF);
      poll(0, 400);
      chk(d[2], 16'h0000);
      rd(4'hC);
      chk(d, 16'h0000);
      repeat (8) @(posedge clk);
      wr(4'h0, 16'h0000);
    end
  endtask
  task t_udr;
    begin
      wr(4'h4, 16'h0004);
      wr(4'h0, 16'h0013);
      wr(4'hC, 16'h1111);
      repeat (2) @(posedge clk);
      slave_run <= 1'b1;
      repeat (8) @(posedge clk);
      chk(bit_clock_oe, 16'h0000);
      while (irq !== 1'b1 && cyc < 20000) @(negedge clk);
      chk(irq, 16'h0001);
      @(posedge clk);
      slave_run <= 1'b0;
      repeat (4) @(posedge clk);
      rd(4'h1);
      chk(d[3], 16'h0001);
      chk(d[2], 16'h0000);
      rd(4'h1);
      chk(d[3], 16'h0000);
      wr(4'h0, 16'h0000);
    end
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_mtx;
    t_mrx;
    t_pad;
    t_udr;
    wrap_up;
  end

  // Hang guard; the whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
endmodule
